// >>> hdl/tac_pkg.sv
// Shared constants, types and register map of the asynchronous timer control block
package tac_pkg;

    // ==========================================================
    // Bus geometry
    localparam int AXI_AW = 12;
    localparam int IDX_W = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [IDX_W-1:0] IDX_GEN_CTRL = 10'h023;
    localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h024;
    localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h026;
    localparam logic [IDX_W-1:0] IDX_COUNTER = 10'h027;
    localparam logic [IDX_W-1:0] IDX_COMPARE = 10'h028;
    localparam logic [IDX_W-1:0] IDX_MASK = 10'h06E;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h015;
    localparam logic [IDX_W-1:0] IDX_ASYNC = 10'h0B6;

    // ==========================================================
    // Field positions
    localparam int GEN_SYNC_BIT = 7;
    localparam int GEN_PRE_RST_BIT = 1;
    localparam int GEN_PSR1_BIT = 0;
    localparam int ASY_EXT_CLK_BIT = 6;
    localparam int ASY_SEL_BIT = 5;
    localparam int IRQ_CMP_BIT = 1;
    localparam int IRQ_OVF_BIT = 0;
    localparam int BUSY_CNT = 3;
    localparam int BUSY_CMP = 2;
    localparam int BUSY_CA = 1;
    localparam int BUSY_CB = 0;
    localparam int COM_HI = 7;
    localparam int COM_LO = 6;
    localparam int WGM_HI = 1;
    localparam int WGM_LO = 0;
    localparam int CS_HI = 2;
    localparam int CS_LO = 0;
    localparam logic [7:0] CTRL_A_RD_MASK = 8'hC3;
    localparam logic [7:0] CTRL_B_RD_MASK = 8'h07;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ==========================================================
    // Counting and prescaler
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_STEP = 8'h01;
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_STEP = 10'h001;
    localparam logic [PRE_W-1:0] TAP_8 = 10'h007;
    localparam logic [PRE_W-1:0] TAP_32 = 10'h01F;
    localparam logic [PRE_W-1:0] TAP_64 = 10'h03F;
    localparam logic [PRE_W-1:0] TAP_128 = 10'h07F;
    localparam logic [PRE_W-1:0] TAP_256 = 10'h0FF;
    localparam logic [PRE_W-1:0] TAP_1024 = 10'h3FF;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef enum logic [2:0] {CS_STOP, CS_DIRECT, CS_DIV8, CS_DIV32, CS_DIV64, CS_DIV128,
        CS_DIV256, CS_DIV1024} tac_clk_sel_t;
    typedef enum logic [1:0] {WGM_NORMAL, WGM_PHASE, WGM_CTC, WGM_FAST} tac_wgm_t;

    // ==========================================================
    // Bus carriers
    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } tac_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tac_axi_rsp_t;

    // ==========================================================
    // Whole state of the block
    typedef struct packed {
        tac_axi_rsp_t rsp;
        logic aw_held;
        logic w_held;
        logic [IDX_W-1:0] w_idx;
        logic [7:0] w_byte;
        logic w_lane;
        logic sync1;
        logic sync2;
        logic sync3;
        logic [7:0] counter;
        logic [7:0] counter_tmp;
        logic [7:0] compare;
        logic [7:0] compare_tmp;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_a_tmp;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_b_tmp;
        logic [3:0] busy;
        logic ext_clk_en;
        logic async_sel;
        logic [1:0] mask;
        logic [1:0] flags;
        logic sync_mode;
        logic pre_rst;
        logic psr1;
        logic [PRE_W-1:0] prescaler;
        logic count_down;
        logic match_block;
        logic wave;
        logic cmp_irq;
        logic ovf_irq;
        logic osc_en;
        logic buf_en;
    } tac_state_t;

endpackage

// >>> hdl/tac_timer0_async.sv
// Timer0 register side: async clocking, update-busy handshake, flags and prescaler reset
`timescale 1ns/10ps
// How it works
// - Compare value matched against counter every tick but the one after a counter write
// - External clock bit picks buffer over crystal
// - Async select picks I/O or pin clock
// - Changing async select drops pending updates
// - Async select kept only with internal sysclk
// - Async writes set busy until loaded
// - Counter reads live; compare and both control registers read temporary
// - Compare irq needs enable, global, flag
// - Overflow irq needs enable, global, flag
// - Compare flag set on match, W1C/vector
// - Overflow flag set on overflow, W1C/vector
// - Phase mode overflow at bottom reversal
// - Unused status, mask, flag bits read zero
// - Prescaler reset bit self-clears outside sync mode
// - Async prescaler reset holds until done
// - Sync mode bit holds prescaler reset
// - Clearing sync mode clears both resets
module tac_timer0_async (
    input wire logic clk,
    input wire logic rst,
    input wire tac_pkg::tac_axi_req_t axi_req,
    output tac_pkg::tac_axi_rsp_t axi_rsp,
    input wire logic global_interrupt_enable,
    input wire logic compare_vector_taken,
    input wire logic overflow_vector_taken,
    input wire logic sysclk_internal_osc,
    input wire logic crystal_input_pin,
    output logic waveform_output_pin,
    output logic compare_irq,
    output logic overflow_irq,
    output logic crystal_osc_enable,
    output logic ext_clock_buffer_enable,
    output logic prescaler1_reset
);
    import tac_pkg::*;

    tac_state_t s;
    tac_state_t n;
    logic async_edge;
    logic src_tick;
    logic timer_tick;
    logic cmp_hit;
    logic ovf_hit;
    logic at_top;
    logic wr_go;
    logic wr_hit;
    logic rd_go;
    logic [8:0] rd_word;
    logic [8:0] wr_word;
    logic [7:0] top;
    tac_wgm_t wgm;
    logic [1:0] com;

    // ==========================================================
    // Decoding shared by reads and write acceptance
    function automatic logic [8:0] read_reg(input tac_state_t st, input logic [IDX_W-1:0] idx);
        logic [8:0] r;
        r = {1'b1, REG_RESET};
        unique case (idx)
            IDX_GEN_CTRL: r[7:0] = {st.sync_mode, 5'h00, st.pre_rst, st.psr1};
            IDX_CTRL_A: r[7:0] = st.ctrl_a_tmp & CTRL_A_RD_MASK;
            IDX_CTRL_B: r[7:0] = st.ctrl_b_tmp & CTRL_B_RD_MASK;
            IDX_COUNTER: r[7:0] = st.counter;
            IDX_COMPARE: r[7:0] = st.compare_tmp;
            IDX_MASK: r[7:0] = {6'h00, st.mask};
            IDX_FLAGS: r[7:0] = {6'h00, st.flags};
            IDX_ASYNC: r[7:0] = {1'b0, st.ext_clk_en, st.async_sel, st.busy[BUSY_CNT],
                st.busy[BUSY_CMP], 1'b0, st.busy[BUSY_CA], st.busy[BUSY_CB]};
            default: r = {1'b0, REG_RESET};
        endcase
        return r;
    endfunction

    // Prescaler tap: all low bits set means the divided edge is due
    function automatic logic tap_hit(input logic [2:0] cs, input logic [PRE_W-1:0] pre);
        logic h;
        h = 1'b0;
        unique case (tac_clk_sel_t'(cs))
            CS_STOP: h = 1'b0;
            CS_DIRECT: h = 1'b1;
            CS_DIV8: h = (pre & TAP_8) == TAP_8;
            CS_DIV32: h = (pre & TAP_32) == TAP_32;
            CS_DIV64: h = (pre & TAP_64) == TAP_64;
            CS_DIV128: h = (pre & TAP_128) == TAP_128;
            CS_DIV256: h = (pre & TAP_256) == TAP_256;
            CS_DIV1024: h = (pre & TAP_1024) == TAP_1024;
        endcase
        return h;
    endfunction

    // ==========================================================
    // Timer clock source and events
    // Second and third stages only; the first stage feeds nothing else
    assign async_edge = s.sync2 & ~s.sync3;
    assign src_tick = s.async_sel ? async_edge : 1'b1;
    assign timer_tick = src_tick & tap_hit(s.ctrl_b[CS_HI:CS_LO], s.prescaler);
    assign wgm = tac_wgm_t'(s.ctrl_a[WGM_HI:WGM_LO]);
    assign com = s.ctrl_a[COM_HI:COM_LO];
    assign top = (wgm == WGM_CTC) ? s.compare : CNT_MAX;
    assign at_top = s.counter == top;
    // A counter write masks the match on the following tick
    assign cmp_hit = timer_tick & (s.counter == s.compare) & ~s.match_block;
    assign ovf_hit = timer_tick & ((wgm == WGM_PHASE)
        ? (s.counter == CNT_BOTTOM) & s.count_down
        : (s.counter == CNT_MAX));

    // Bus handshakes
    assign wr_go = s.aw_held & s.w_held;
    assign rd_go = axi_req.arvalid & s.rsp.arready;
    assign rd_word = read_reg(s, axi_req.araddr[AXI_AW-1:2]);
    assign wr_word = read_reg(s, s.w_idx);
    assign wr_hit = wr_word[8];

    // ==========================================================
    // Next state
    always_comb begin
        logic [1:0] flag_clr;
        logic [1:0] flag_set;
        logic wr_en;
        flag_clr = 2'h0;
        flag_set = 2'h0;
        wr_en = wr_go & s.w_lane & wr_hit;
        n = s;

        // Pin synchroniser for the asynchronous timer clock
        n.sync1 = crystal_input_pin;
        n.sync2 = s.sync1;
        n.sync3 = s.sync2;

        // Prescaler runs free except while its reset bit is set
        if (s.pre_rst) begin
            n.prescaler = '0;
        end else if (src_tick) begin
            n.prescaler = s.prescaler + PRE_STEP;
        end

        // Counting sequence
        if (timer_tick) begin
            n.match_block = 1'b0;
            if (wgm == WGM_PHASE) begin
                if (s.count_down) begin
                    if (s.counter == CNT_BOTTOM) begin
                        n.count_down = 1'b0;
                        n.counter = s.counter + CNT_STEP;
                    end else begin
                        n.counter = s.counter - CNT_STEP;
                    end
                end else if (s.counter == CNT_MAX) begin
                    n.count_down = 1'b1;
                    n.counter = s.counter - CNT_STEP;
                end else begin
                    n.counter = s.counter + CNT_STEP;
                end
            end else begin
                n.count_down = 1'b0;
                n.counter = at_top ? CNT_BOTTOM : s.counter + CNT_STEP;
            end
        end

        // Waveform pin follows the compare output mode
        unique case (wgm)
            WGM_NORMAL, WGM_CTC: begin
                if (cmp_hit) begin
                    unique case (com)
                        COM_TOGGLE: n.wave = ~s.wave;
                        COM_CLEAR: n.wave = 1'b0;
                        COM_SET: n.wave = 1'b1;
                        default: n.wave = s.wave;
                    endcase
                end
            end
            WGM_FAST: begin
                if (com == COM_CLEAR || com == COM_SET) begin
                    if (cmp_hit) begin
                        n.wave = (com == COM_SET);
                    end else if (timer_tick && at_top) begin
                        n.wave = (com == COM_CLEAR);
                    end
                end
            end
            WGM_PHASE: begin
                if (cmp_hit && (com == COM_CLEAR || com == COM_SET)) begin
                    n.wave = (com == COM_SET) ^ s.count_down;
                end
            end
        endcase

        // Pending asynchronous updates land on a synchronised timer clock edge
        if (s.async_sel && async_edge) begin
            if (s.busy[BUSY_CNT]) begin
                n.counter = s.counter_tmp;
                n.match_block = 1'b1;
            end
            if (s.busy[BUSY_CMP]) begin
                n.compare = s.compare_tmp;
            end
            if (s.busy[BUSY_CA]) begin
                n.ctrl_a = s.ctrl_a_tmp;
            end
            if (s.busy[BUSY_CB]) begin
                n.ctrl_b = s.ctrl_b_tmp;
            end
            n.busy = 4'h0;
        end

        // Prescaler reset self-clear, held by synchronisation mode
        if (!s.sync_mode) begin
            n.psr1 = 1'b0;
            if (!s.async_sel) begin
                n.pre_rst = 1'b0;
            end else if (async_edge) begin
                n.pre_rst = 1'b0;
            end
        end

        // Register writes
        if (wr_en) begin
            unique case (s.w_idx)
                IDX_GEN_CTRL: begin
                    n.sync_mode = s.w_byte[GEN_SYNC_BIT];
                    if (s.sync_mode && !s.w_byte[GEN_SYNC_BIT]) begin
                        n.pre_rst = 1'b0;
                        n.psr1 = 1'b0;
                    end else begin
                        n.pre_rst = n.pre_rst | s.w_byte[GEN_PRE_RST_BIT];
                        n.psr1 = n.psr1 | s.w_byte[GEN_PSR1_BIT];
                    end
                end
                IDX_CTRL_A: begin
                    n.ctrl_a_tmp = s.w_byte;
                    if (s.async_sel) begin
                        n.busy[BUSY_CA] = 1'b1;
                    end else begin
                        n.ctrl_a = s.w_byte;
                    end
                end
                IDX_CTRL_B: begin
                    n.ctrl_b_tmp = s.w_byte;
                    if (s.async_sel) begin
                        n.busy[BUSY_CB] = 1'b1;
                    end else begin
                        n.ctrl_b = s.w_byte;
                    end
                end
                IDX_COUNTER: begin
                    n.counter_tmp = s.w_byte;
                    if (s.async_sel) begin
                        n.busy[BUSY_CNT] = 1'b1;
                    end else begin
                        n.counter = s.w_byte;
                        n.match_block = 1'b1;
                    end
                end
                IDX_COMPARE: begin
                    n.compare_tmp = s.w_byte;
                    if (s.async_sel) begin
                        n.busy[BUSY_CMP] = 1'b1;
                    end else begin
                        n.compare = s.w_byte;
                    end
                end
                IDX_MASK: n.mask = s.w_byte[1:0];
                IDX_FLAGS: flag_clr = s.w_byte[1:0];
                IDX_ASYNC: begin
                    n.ext_clk_en = s.w_byte[ASY_EXT_CLK_BIT];
                    n.async_sel = s.w_byte[ASY_SEL_BIT];
                    // Switching domains abandons what was in flight
                    if (s.w_byte[ASY_SEL_BIT] != s.async_sel) begin
                        n.busy = 4'h0;
                    end
                end
                default: n.mask = s.mask;
            endcase
        end
        // Pin clocking only when the system clock is internal
        n.async_sel = n.async_sel & sysclk_internal_osc;

        // Flags: a new event wins over a clear in the same cycle
        flag_clr[IRQ_CMP_BIT] = flag_clr[IRQ_CMP_BIT] | compare_vector_taken;
        flag_clr[IRQ_OVF_BIT] = flag_clr[IRQ_OVF_BIT] | overflow_vector_taken;
        flag_set[IRQ_CMP_BIT] = cmp_hit;
        flag_set[IRQ_OVF_BIT] = ovf_hit;
        n.flags = (s.flags & ~flag_clr) | flag_set;

        // Interrupt requests and clock pin control
        n.cmp_irq = s.flags[IRQ_CMP_BIT] & s.mask[IRQ_CMP_BIT] & global_interrupt_enable;
        n.ovf_irq = s.flags[IRQ_OVF_BIT] & s.mask[IRQ_OVF_BIT] & global_interrupt_enable;
        n.osc_en = s.async_sel & ~s.ext_clk_en;
        n.buf_en = s.async_sel & s.ext_clk_en;

        // Write channels, taken in either order
        if (axi_req.awvalid && s.rsp.awready) begin
            n.aw_held = 1'b1;
            n.w_idx = axi_req.awaddr[AXI_AW-1:2];
        end
        if (axi_req.wvalid && s.rsp.wready) begin
            n.w_held = 1'b1;
            n.w_byte = axi_req.wdata[7:0];
            n.w_lane = axi_req.wstrb[0];
        end
        if (s.rsp.bvalid && axi_req.bready) begin
            n.rsp.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        n.rsp.awready = ~n.aw_held & ~n.rsp.bvalid & ~wr_go;
        n.rsp.wready = ~n.w_held & ~n.rsp.bvalid & ~wr_go;

        // Read channel: one outstanding read, answered next cycle
        if (s.rsp.rvalid && axi_req.rready) begin
            n.rsp.rvalid = 1'b0;
        end
        if (rd_go) begin
            n.rsp.rvalid = 1'b1;
            n.rsp.rdata = {24'h000000, rd_word[7:0]};
            n.rsp.rresp = rd_word[8] ? RESP_OKAY : RESP_SLVERR;
        end
        n.rsp.arready = ~n.rsp.rvalid & ~rd_go;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from state
    assign axi_rsp = s.rsp;
    assign waveform_output_pin = s.wave;
    assign compare_irq = s.cmp_irq;
    assign overflow_irq = s.ovf_irq;
    assign crystal_osc_enable = s.osc_en;
    assign ext_clock_buffer_enable = s.buf_en;
    assign prescaler1_reset = s.psr1;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cmp_irq_req: assert property ((s.flags[IRQ_CMP_BIT] && s.mask[IRQ_CMP_BIT]
        && global_interrupt_enable) |=> compare_irq)
        else $error("compare irq not raised");
    a_ovf_irq_cause: assert property (overflow_irq |-> $past(s.flags[IRQ_OVF_BIT])
        && $past(s.mask[IRQ_OVF_BIT]) && $past(global_interrupt_enable))
        else $error("overflow irq without cause");
    a_cmp_flag_set: assert property (cmp_hit |=> s.flags[IRQ_CMP_BIT])
        else $error("compare flag missed");
    a_ovf_flag_set: assert property (ovf_hit |=> s.flags[IRQ_OVF_BIT])
        else $error("overflow flag missed");
    a_phase_ovf_bottom: assert property ((timer_tick && wgm == WGM_PHASE && s.count_down
        && s.counter == CNT_BOTTOM) |=> s.flags[IRQ_OVF_BIT])
        else $error("phase overflow off bottom");
    a_reserved_zero: assert property ((rd_go && (axi_req.araddr[AXI_AW-1:2] == IDX_MASK
        || axi_req.araddr[AXI_AW-1:2] == IDX_FLAGS)) |=> axi_rsp.rdata[7:2] == 6'h00)
        else $error("reserved bits not zero");
    a_async_forced: assert property (!sysclk_internal_osc |=> !s.async_sel)
        else $error("async select kept on external sysclk");
    a_busy_set: assert property ((wr_go && s.w_lane && s.w_idx == IDX_COMPARE && s.async_sel
        && sysclk_internal_osc) |=> s.busy[BUSY_CMP] && s.compare_tmp == $past(s.w_byte))
        else $error("compare busy not set");
    a_busy_load: assert property ((s.busy[BUSY_CMP] && s.async_sel && async_edge && !wr_go)
        |=> !s.busy[BUSY_CMP] && s.compare == s.compare_tmp)
        else $error("compare not loaded on timer edge");
    a_psr_sync_clear: assert property ((s.pre_rst && !s.sync_mode && !s.async_sel && !wr_go)
        |=> !s.pre_rst)
        else $error("prescaler reset not self cleared");
    // A write landing on either of the next two edges may legally release the hold
    a_psr_tsm_hold: assert property (((s.pre_rst && s.sync_mode && !wr_go) ##1 !wr_go)
        |-> s.pre_rst [*2])
        else $error("prescaler reset dropped in sync mode");
    a_clock_pins: assert property (crystal_osc_enable |-> !ext_clock_buffer_enable
        && $past(s.async_sel))
        else $error("crystal and buffer both on");
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the timer0 async control block over AXI4-Lite
`timescale 1ns/10ps
module tb_top;
    import tac_pkg::*;
    // ==========================================================
    // Stimulus rows: osc, write, index, write data, read expect, response
    typedef struct packed {
        logic osc;
        logic wr;
        logic [IDX_W-1:0] idx;
        logic [7:0] wd;
        logic [31:0] rd;
        logic [1:0] resp;
    } tac_row_t;
    localparam tac_row_t ROWS [9] = '{
        '{1'b1, 1'b0, IDX_MASK, 8'h00, 32'h0, RESP_OKAY},
        '{1'b1, 1'b0, IDX_FLAGS, 8'h00, 32'h0, RESP_OKAY},
        '{1'b1, 1'b0, IDX_ASYNC, 8'h00, 32'h0, RESP_OKAY},
        '{1'b1, 1'b0, IDX_GEN_CTRL, 8'h00, 32'h0, RESP_OKAY},
        '{1'b1, 1'b0, IDX_COMPARE, 8'h00, 32'h0, RESP_OKAY},
        '{1'b1, 1'b1, IDX_MASK, 8'hFF, 32'h3, RESP_OKAY},
        '{1'b1, 1'b1, IDX_COMPARE, 8'h5A, 32'h5A, RESP_OKAY},
        '{1'b0, 1'b1, IDX_ASYNC, 8'h20, 32'h0, RESP_OKAY},
        '{1'b1, 1'b0, 10'h100, 8'h00, 32'h0, RESP_SLVERR}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    tac_axi_req_t req = '0;
    tac_axi_rsp_t rsp;
    logic gie = 1'b0, cmp_vec = 1'b0, ovf_vec = 1'b0, osc = 1'b1, xtal = 1'b0;
    logic wave, cmp_irq, ovf_irq, osc_en, buf_en, psr1;
    logic [31:0] rdat;
    logic [1:0] rres;
    int miscompares = 0;
    int tests_run = 0;
    tac_timer0_async i_dut (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .global_interrupt_enable(gie), .compare_vector_taken(cmp_vec),
        .overflow_vector_taken(ovf_vec), .sysclk_internal_osc(osc), .crystal_input_pin(xtal),
        .waveform_output_pin(wave), .compare_irq(cmp_irq), .overflow_irq(ovf_irq),
        .crystal_osc_enable(osc_en), .ext_clock_buffer_enable(buf_en), .prescaler1_reset(psr1));
    // ==========================================================
    // Clock, verdict and comparison
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic complete_run();
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ==========================================================
    // Bus master; every wait bounded, a hang ends the run
    task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= {idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        if (n == 50) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic axi_read(input logic [IDX_W-1:0] idx);
        int n;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= {idx, 2'b00};
        req.rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        rdat = rsp.rdata;
        rres = rsp.rresp;
        req.rready <= 1'b0;
        if (n == 50) begin
            miscompares++;
            complete_run();
        end
    endtask
    // Interrupt wait; the bound covers a full 256-tick wrap
    task automatic wait_irq(input bit ovf);
        int n;
        for (n = 0; n < 600 && (ovf ? ovf_irq : cmp_irq) !== 1'b1; n++) @(posedge clk);
        if (n == 600) begin
            miscompares++;
            complete_run();
        end
    endtask
    // ==========================================================
    // Main sequence: table rows first, then hand-written cases
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (ROWS[i]) begin
            osc <= ROWS[i].osc;
            if (ROWS[i].wr) axi_write(ROWS[i].idx, ROWS[i].wd);
            axi_read(ROWS[i].idx);
            check(rdat, ROWS[i].rd);
            check(32'(rres), 32'(ROWS[i].resp));
        end
        osc <= 1'b1;
        // Prescaler reset self-clear, hold under sync mode, release
        axi_write(IDX_GEN_CTRL, 8'h02);
        axi_read(IDX_GEN_CTRL);
        check(rdat, 32'h0);
        axi_write(IDX_GEN_CTRL, 8'h83);
        axi_read(IDX_GEN_CTRL);
        check(rdat, 32'h83);
        check(32'(psr1), 32'h1);
        axi_write(IDX_GEN_CTRL, 8'h00);
        axi_read(IDX_GEN_CTRL);
        check(rdat, 32'h0);
        check(32'(psr1), 32'h0);
        // Compare then overflow interrupt, vector clear, W1C clear
        gie <= 1'b1;
        axi_write(IDX_COMPARE, 8'h05);
        axi_write(IDX_MASK, 8'h02);
        axi_write(IDX_CTRL_B, 8'h01);
        wait_irq(1'b0);
        axi_write(IDX_MASK, 8'h01);
        wait_irq(1'b1);
        axi_write(IDX_CTRL_B, 8'h00);
        @(posedge clk);
        ovf_vec <= 1'b1;
        @(posedge clk);
        ovf_vec <= 1'b0;
        axi_read(IDX_FLAGS);
        check(rdat, 32'h2);
        axi_write(IDX_FLAGS, 8'h02);
        axi_read(IDX_FLAGS);
        check(rdat, 32'h0);
        check(32'(ovf_irq), 32'h0);
        // Set-on-match pin, then phase-correct overflow at the bottom turn
        axi_write(IDX_CTRL_A, 8'hC0);
        axi_write(IDX_MASK, 8'h02);
        check(32'(wave), 32'h0);
        axi_write(IDX_CTRL_B, 8'h01);
        wait_irq(1'b0);
        check(32'(wave), 32'h1);
        axi_write(IDX_CTRL_B, 8'h00);
        axi_write(IDX_CTRL_A, 8'h01);
        axi_write(IDX_COUNTER, 8'hF0);
        axi_write(IDX_FLAGS, 8'h03);
        axi_write(IDX_MASK, 8'h01);
        axi_write(IDX_CTRL_B, 8'h01);
        wait_irq(1'b1);
        axi_read(IDX_COUNTER);
        check(32'(rdat[7:4]), 32'h0);
        axi_write(IDX_CTRL_B, 8'h00);
        // Async clocking: clock bit first, then select
        axi_write(IDX_ASYNC, 8'h40);
        axi_write(IDX_ASYNC, 8'h60);
        repeat (2) @(posedge clk);
        check(32'({buf_en, osc_en}), 32'h2);
        axi_write(IDX_COMPARE, 8'h33);
        axi_read(IDX_ASYNC);
        check(rdat, 32'h68);
        axi_read(IDX_COMPARE);
        check(rdat, 32'h33);
        // One slow pin edge must cross and clear the busy bit
        xtal <= 1'b1;
        repeat (6) @(posedge clk);
        xtal <= 1'b0;
        repeat (6) @(posedge clk);
        axi_read(IDX_ASYNC);
        check(rdat, 32'h60);
        axi_write(IDX_ASYNC, 8'h20);
        repeat (2) @(posedge clk);
        check(32'({buf_en, osc_en}), 32'h1);
        osc <= 1'b0;
        repeat (2) @(posedge clk);
        axi_read(IDX_ASYNC);
        check(rdat, 32'h0);
        // Mid-run reset returns pins and stored values to idle
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'({wave, psr1, buf_en, osc_en}), 32'h0);
        axi_read(IDX_COMPARE);
        check(rdat, 32'h0);
        complete_run();
    end
endmodule
